// ==== shadow_bank.v ====
// serial-port register bank with shadowed program registers, two channels
// assumes serial pins are asynchronous to clk_sys and slower than clk_sys/4
//
// Overview of operation
// - program range writes land in shadow copies, no effect until transfer
// - writing 0x01 to the transfer address is the transfer command
// - transfer copies every shadow entry into its active copy at once
// - transfer bit clears itself after the internal update
// - local registers exist once per channel at the same address
// - channel select bit 0 picks channel A, bit 1 picks channel B
// - both select bits set: a local write updates both channels
// - both select bits set on a read: channel A copy is returned
// - global registers ignore the channel select contents
// - channel select resets with both channels enabled
// - grade register is read-only, speed field 000 means 250 MSPS
// - unmapped addresses hold no storage, read zero, writes dropped
// - reset loads registers with their default values
`timescale 1ns/1ps
`default_nettype none
`include "shadow_bank_consts.vh"

module shadow_bank
#(
   parameter [7:0]  IDENTIFICATION     = 8'h5C,      // arbitrary value
   parameter [2:0]  SPEED_GRADE = 3'b000,
   parameter        PROG_DEPTH  = 49,
   parameter [48:0] GLOBAL_MASK = 49'h0
)
(
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // serial port pins
   input  wire       sclk,
   input  wire       csb_n,
   input  wire       sdio_i,
   output reg        sdio_o,
   output wire       sdio_oe,
   // active settings read port
   input  wire [5:0] act_idx,
   output reg  [7:0] act_a,
   output reg  [7:0] act_b,
   output reg        xfer_done,
   output reg        lsb_first
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [12:0] step;
      input [12:0] a;
      input        lsb;
      begin
         step = lsb ? a + 13'h0001 : a - 13'h0001;
      end
   endfunction

   function in_prog;
      input [12:0] a;
      begin
         in_prog = (a >= `ADDR_PROG_LO) && (a <= `ADDR_PROG_HI);
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg        sclk_s1;
   reg        sclk_s2;
   reg        sclk_s3;
   reg        cs_s1;
   reg        cs_s2;
   reg        sdi_s1;
   reg        sdi_s2;

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
      end
      else
      begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1   <= csb_n;
         cs_s2   <= cs_s1;
         sdi_s1  <= sdio_i;
         sdi_s2  <= sdi_s1;
      end
   end

   wire rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
   wire fall = ~sclk_s2 & sclk_s3 & ~cs_s2;

   // ----------------------------------------
   // frame engine
   // ----------------------------------------
   reg  [15:0] ish_q;
   reg  [4:0]  icnt_q;
   reg         in_data_q;
   reg         rd_q;
   reg  [1:0]  len_q;
   reg  [1:0]  bytes_q;
   reg         done_q;
   reg  [12:0] addr_q;
   reg  [7:0]  wsh_q;
   reg  [2:0]  bcnt_q;
   reg  [7:0]  rsh_q;
   reg         wr_stb_q;
   reg  [12:0] wr_addr_q;
   reg  [7:0]  wr_data_q;
   reg  [7:0]  rdata;

   wire [15:0] ish_d = lsb_first ? {sdi_s2, ish_q[15:1]} : {ish_q[14:0], sdi_s2};
   wire [7:0]  wsh_d = lsb_first ? {sdi_s2, wsh_q[7:1]} : {wsh_q[6:0], sdi_s2};
   wire [12:0] rd_addr = in_data_q ? step(addr_q, lsb_first) : ish_d[12:0];

   assign sdio_oe = in_data_q & rd_q & ~cs_s2;

   always @(posedge clk_sys)
   begin
      wr_stb_q <= 1'b0;
      if (rst || cs_s2)
      begin
         ish_q     <= 16'h0000;
         icnt_q    <= 5'h00;
         in_data_q <= 1'b0;
         rd_q      <= 1'b0;
         len_q     <= 2'h0;
         bytes_q   <= 2'h0;
         done_q    <= 1'b0;
         addr_q    <= 13'h0000;
         wsh_q     <= 8'h00;
         bcnt_q    <= 3'h0;
         rsh_q     <= 8'h00;
         sdio_o    <= 1'b0;
         wr_addr_q <= 13'h0000;
         wr_data_q <= 8'h00;
      end
      else if (rise && !in_data_q)
      begin
         ish_q  <= ish_d;
         icnt_q <= icnt_q + 5'h01;
         if (icnt_q == `INSTR_LAST)
         begin
            in_data_q <= 1'b1;
            rd_q      <= ish_d[`INSTR_RW];
            len_q     <= ish_d[`INSTR_LEN_HI:`INSTR_LEN_LO];
            addr_q    <= ish_d[12:0];
            rsh_q     <= rdata;
         end
      end
      else if (rise)
      begin
         wsh_q  <= wsh_d;
         bcnt_q <= bcnt_q + 3'h1;
         if (bcnt_q == `BYTE_LAST)
         begin
            addr_q  <= step(addr_q, lsb_first);
            rsh_q   <= rdata;
            bytes_q <= bytes_q + 2'h1;
            if (bytes_q == len_q && len_q != `LEN_STREAM)
               done_q <= 1'b1;
            if (!rd_q && !done_q)
            begin
               wr_stb_q  <= 1'b1;
               wr_addr_q <= addr_q;
               wr_data_q <= wsh_d;
            end
         end
      end
      else if (fall && in_data_q && rd_q)
      begin
         sdio_o <= lsb_first ? rsh_q[0] : rsh_q[7];
         rsh_q  <= lsb_first ? {1'b0, rsh_q[7:1]} : {rsh_q[6:0], 1'b0};
      end
   end

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   reg  [7:0] sh_a  [0:PROG_DEPTH-1];
   reg  [7:0] sh_b  [0:PROG_DEPTH-1];
   reg  [7:0] act_a_m [0:PROG_DEPTH-1];
   reg  [7:0] act_b_m [0:PROG_DEPTH-1];
   reg  [1:0] chsel_q;
   reg        xfer_q;
   reg        srst_q;
   integer    i;

   // reset images, cut to the width of each register on purpose
   localparam [7:0] CFG_RST_V   = `PORT_CFG_RST;
   localparam [7:0] CHSEL_RST_V = `CHSEL_RST;
   localparam [7:0] XFER_RST_V  = `XFER_RST;

   wire [5:0] widx = wr_addr_q[5:0] - 6'h08;
   wire       wglob = GLOBAL_MASK[widx];
   wire       wr_a = wglob | chsel_q[`CHSEL_A];
   wire       wr_b = wglob | chsel_q[`CHSEL_B];

   always @(posedge clk_sys)
   begin
      srst_q    <= 1'b0;
      xfer_done <= 1'b0;
      if (rst || srst_q)
      begin
         chsel_q   <= CHSEL_RST_V[1:0];
         lsb_first <= CFG_RST_V[`CFG_LSB_LO];
         xfer_q    <= XFER_RST_V[`XFER_BIT];
         for (i = 0; i < PROG_DEPTH; i = i + 1)
         begin
            sh_a[i]    <= `PROG_RST;
            sh_b[i]    <= `PROG_RST;
            act_a_m[i] <= `PROG_RST;
            act_b_m[i] <= `PROG_RST;
         end
      end
      else
      begin
         if (xfer_q)
         begin
            for (i = 0; i < PROG_DEPTH; i = i + 1)
            begin
               act_a_m[i] <= sh_a[i];
               act_b_m[i] <= sh_b[i];
            end
            xfer_q    <= 1'b0;
            xfer_done <= 1'b1;
         end
         if (wr_stb_q)
         begin
            case (wr_addr_q)
               `ADDR_PORT_CFG:
               begin
                  lsb_first <= wr_data_q[`CFG_LSB_HI] | wr_data_q[`CFG_LSB_LO];
                  srst_q    <= wr_data_q[`CFG_SRST_HI] | wr_data_q[`CFG_SRST_LO];
               end
               `ADDR_CHSEL:
                  chsel_q <= wr_data_q[1:0];
               `ADDR_XFER:
                  if (wr_data_q == `XFER_CMD)
                     xfer_q <= 1'b1;
               default:
                  if (in_prog(wr_addr_q))
                  begin
                     if (wr_a)
                        sh_a[widx] <= wr_data_q;
                     if (wr_b)
                        sh_b[widx] <= wr_data_q;
                  end
            endcase
         end
      end
   end

   // ----------------------------------------
   // active settings out
   // ----------------------------------------
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         act_a <= `PROG_RST;
         act_b <= `PROG_RST;
      end
      else if (act_idx < PROG_DEPTH)
      begin
         act_a <= act_a_m[act_idx];
         act_b <= act_b_m[act_idx];
      end
      else
      begin
         act_a <= 8'h00;
         act_b <= 8'h00;
      end
   end

   // ----------------------------------------
   // read decode
   // ----------------------------------------
   wire [5:0] ridx = rd_addr[5:0] - 6'h08;

   always @*
   begin
      rdata = 8'h00;
      case (rd_addr)
         `ADDR_PORT_CFG:
         begin
            rdata = `PORT_CFG_RST;
            rdata[`CFG_LSB_HI] = lsb_first;
            rdata[`CFG_LSB_LO] = lsb_first;
         end
         `ADDR_IDENT:
            rdata = IDENTIFICATION;
         `ADDR_GRADE:
            rdata = `GRADE_RST | {1'b0, SPEED_GRADE, 4'h0};
         `ADDR_CHSEL:
            rdata = {6'h00, chsel_q};
         `ADDR_XFER:
            rdata = {7'h00, xfer_q};
         default:
            if (in_prog(rd_addr))
            begin
               if (chsel_q[`CHSEL_A] || !chsel_q[`CHSEL_B] || GLOBAL_MASK[ridx])
                  rdata = sh_a[ridx];
               else
                  rdata = sh_b[ridx];
            end
      endcase
   end

endmodule
`default_nettype wire

// ==== shadow_bank_consts.vh ====
// constants for the shadowed dual-channel register bank
// assumes 13-bit register addresses and 8-bit registers
`ifndef SHADOW_BANK_CONSTS_VH
`define SHADOW_BANK_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_PORT_CFG 13'h0000
`define ADDR_IDENT    13'h0001
`define ADDR_GRADE    13'h0002
`define ADDR_CHSEL    13'h0005
`define ADDR_XFER     13'h00FF
`define ADDR_PROG_LO  13'h0008
`define ADDR_PROG_HI  13'h0038

// ----------------------------------------
// reset values and commands
// ----------------------------------------
`define PORT_CFG_RST  8'h18
`define GRADE_RST     8'h00
`define CHSEL_RST     8'hFF
`define XFER_RST      8'h00
`define PROG_RST      8'h00
`define XFER_CMD      8'h01

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_LSB_HI    6
`define CFG_LSB_LO    1
`define CFG_SRST_HI   5
`define CFG_SRST_LO   2
`define GRADE_LSB     4
`define CHSEL_A       0
`define CHSEL_B       1
`define XFER_BIT      0
`define INSTR_RW      15
`define INSTR_LEN_HI  14
`define INSTR_LEN_LO  13
`define INSTR_LAST    5'h0F
`define BYTE_LAST     3'h7
`define LEN_STREAM    2'h3

`endif

// ==== shadow_bank_props.sv ====
// checker for the shadowed register bank
// sees only the top ports of shadow_bank
`timescale 1ns/1ps
`default_nettype none
module shadow_bank_props
#(
   parameter [48:0] GLOBAL_MASK = 49'h0
)
(
   // clock and reset
   input wire       clk_sys,
   input wire       rst,
   // serial pins
   input wire       sclk,
   input wire       csb_n,
   input wire       sdio_i,
   input wire       sdio_o,
   input wire       sdio_oe,
   // active settings
   input wire [5:0] act_idx,
   input wire [7:0] act_a,
   input wire [7:0] act_b,
   input wire       xfer_done,
   input wire       lsb_first
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_reset_clears: assert property (disable iff (1'b0) rst |=>
      act_a == 8'h00 && act_b == 8'h00 && !sdio_oe && !xfer_done && !lsb_first)
      else $error("outputs not cleared by reset");
   a_done_single: assert property (xfer_done |=> !xfer_done)
      else $error("transfer pulse too long");
   a_act_cause: assert property ($changed(act_a) || $changed(act_b) |->
      $past(xfer_done) || $past(act_idx) != $past(act_idx, 2))
      else $error("active copy moved without transfer");
   a_global_same: assert property (
      act_idx < 6'd49 && GLOBAL_MASK[act_idx] |=> act_a == act_b)
      else $error("global entry differs per channel");
   a_idx_beyond: assert property (act_idx > 6'd48 |=> act_a == 8'h00 && act_b == 8'h00)
      else $error("unmapped index not zero");
   a_xfer_frame: assert property (xfer_done |-> !$past(csb_n, 4))
      else $error("transfer outside a frame");
   a_order_frame: assert property ($changed(lsb_first) |-> !$past(csb_n, 3))
      else $error("shift order moved outside a frame");
   a_read_drive: assert property ($rose(sdio_oe) |-> sclk && !csb_n)
      else $error("data pin driven at wrong time");
endmodule
bind shadow_bank shadow_bank_props #(.GLOBAL_MASK(GLOBAL_MASK)) i_props (.clk_sys, .rst,
   .sclk, .csb_n, .sdio_i, .sdio_o, .sdio_oe, .act_idx, .act_a, .act_b, .xfer_done,
   .lsb_first);
`default_nettype wire

// ==== spi_host_model.sv ====
// serial host model, mode 0, 80 ns serial clock
// clock stands low between frames; released pin toggles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
   // device side of the data pin
   input  wire  dev_o,
   input  wire  dev_oe,
   // pins
   output logic sclk,
   output logic csb_n,
   output wire  sdio
);
   logic host_d;
   logic lsb_mode;
   assign sdio = dev_oe ? dev_o : host_d;
   initial
   begin
      sclk = 1'b0;
      csb_n = 1'b1;
      host_d = 1'b0;
      lsb_mode = 1'b0;
   end
   // ----
   // one frame, one byte, bit order from lsb_mode
   // ----
   task automatic frame(input logic rd, input logic [12:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
      logic [15:0] ins;
      int          b;
      ins = {rd, 2'b00, a};
      q = 8'h00;
      csb_n = 1'b0;
      for (int k = 0; k < 24; k++)
      begin
         if (k < 16)
            b = lsb_mode ? k : 15 - k;
         else
            b = lsb_mode ? k - 16 : 23 - k;
         if (k < 16)
            host_d = ins[b];
         else
            host_d = rd ? ~host_d : wd[b];
         #40 sclk = 1'b1;
         if (k >= 16) q[b] = sdio;
         #40 sclk = 1'b0;
      end
      #40 csb_n = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// ==== shadow_bank_tb.sv ====
// testbench for the shadowed register bank
// drives the serial port through spi_host_model
`timescale 1ns/1ps
`default_nettype none
`include "shadow_bank_consts.vh"
module shadow_bank_tb;
   logic       clk_sys;
   logic       rst;
   logic [5:0] act_idx;
   logic [7:0] q;
   wire        sclk, csb_n, sdio_w, sdio_o, sdio_oe, xfer_done, lsb_first;
   wire  [7:0] act_a, act_b;
   int         error_cnt = 0;
   int         n_tests = 0;
   int         n_done = 0;
   shadow_bank #(.IDENTIFICATION(8'h3C), .GLOBAL_MASK(49'h2)) i_dut (.clk_sys(clk_sys),
      .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_w), .sdio_o(sdio_o),
      .sdio_oe(sdio_oe), .act_idx(act_idx), .act_a(act_a), .act_b(act_b),
      .xfer_done(xfer_done), .lsb_first(lsb_first));
   spi_host_model i_host (.dev_o(sdio_o), .dev_oe(sdio_oe), .sclk(sclk),
      .csb_n(csb_n), .sdio(sdio_w));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (xfer_done === 1'b1) n_done++;
   // ----
   // helpers
   // ----
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      i_host.frame(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      i_host.frame(1'b1, a, 8'h00, q);
      chk("read", e, q);
   endtask
   task automatic act(input logic [5:0] i, input logic [7:0] ea, input logic [7:0] eb);
      @(posedge clk_sys);
      #1 act_idx = i;
      repeat (2) @(posedge clk_sys);
      #1 chk("act_a", ea, act_a);
      chk("act_b", eb, act_b);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      rd(13'h0000, 8'h18);
      rd(13'h0001, 8'h3C);
      rd(13'h0002, 8'h00);
      rd(13'h0005, 8'h03);
      $display("reset test done");
   endtask
   task automatic t_refuse;
      wr(13'h0001, 8'hA5);
      rd(13'h0001, 8'h3C);
      rd(13'h0003, 8'h00);
      wr(13'h0002, 8'h70);
      rd(13'h0002, 8'h00);
      $display("refuse test done");
   endtask
   task automatic t_local;
      wr(13'h0008, 8'h11);
      wr(13'h0038, 8'h5A);
      wr(13'h0005, 8'h02);
      wr(13'h0008, 8'h33);
      wr(13'h0009, 8'h44);
      act(6'h00, 8'h00, 8'h00);
      rd(13'h0008, 8'h33);
      wr(13'h0005, 8'h01);
      rd(13'h0008, 8'h11);
      rd(13'h0009, 8'h44);
      wr(13'h0005, 8'h03);
      rd(13'h0008, 8'h11);
      wr(`ADDR_XFER, 8'h02);
      chk("no transfer", 8'd0, n_done[7:0]);
      wr(`ADDR_XFER, `XFER_CMD);
      chk("one transfer", 8'd1, n_done[7:0]);
      act(6'h00, 8'h11, 8'h33);
      act(6'h30, 8'h5A, 8'h5A);
      act(6'h01, 8'h44, 8'h44);
      act(6'h3F, 8'h00, 8'h00);
      rd(`ADDR_XFER, 8'h00);
      $display("local test done");
   endtask
   task automatic t_order;
      wr(13'h0000, 8'h42);
      chk("lsb_first", 8'h01, {7'h00, lsb_first});
      i_host.lsb_mode = 1'b1;
      rd(13'h0000, 8'h5A);
      wr(13'h000A, 8'h81);
      rd(13'h000A, 8'h81);
      wr(13'h0000, 8'h00);
      i_host.lsb_mode = 1'b0;
      chk("lsb_first", 8'h00, {7'h00, lsb_first});
      rd(13'h0000, 8'h18);
      wr(13'h0005, 8'h01);
      wr(13'h0000, 8'h24);
      rd(13'h0005, 8'h03);
      rd(13'h000A, 8'h00);
      $display("order test done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      act_idx = 6'h00;
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      t_reset();
      t_refuse();
      t_local();
      t_order();
      finish_test();
   end
   initial
   begin
      #200000;
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
